// ### hw/quad_timer_pkg.sv
// Purpose: shared constants and carriers for the quad reload timer block
// Assumes: control nibbles are held by the cpu and presented as plain ports
// Notes:   bit positions below index into each 4-bit control nibble
package quad_timer_pkg;

  // ------------------------------------------------------------------
  // control nibble fields
  // ------------------------------------------------------------------
  localparam int ONE_TRIG_SEL = 0;
  localparam int ONE_RUN = 1;
  localparam int PRE_RATIO = 2;
  localparam int PRE_RUN = 3;
  localparam int SRC_LO = 0;
  localparam int SRC_HI = 1;
  localparam int TMR_RUN = 3;
  localparam int THREE_TRIG_SEL = 2;
  localparam int PIN0_FUNC = 0;
  localparam int PIN0_AND = 1;
  localparam int PIN1_FUNC = 2;
  localparam int PIN1_AND = 3;

  // ------------------------------------------------------------------
  // count source codes and counts
  // ------------------------------------------------------------------
  localparam logic [1:0] SRC_CASCADE = 2'h0;
  localparam logic [1:0] SRC_PRESCALE = 2'h1;
  localparam logic [1:0] SRC_PIN = 2'h2;
  localparam int PRE_DIV_SLOW = 16;
  localparam int PRE_DIV_FAST = 4;
  localparam logic [7:0] CNT_RESET = 8'h00;

  typedef struct packed {
    logic [3:0] pinCtrl;
    logic [3:0] fourCtrl;
    logic [3:0] threeCtrl;
    logic [3:0] twoCtrl;
    logic [3:0] oneCtrl;
  } timer_ctrl_t;

  typedef struct packed {
    logic [3:0] loadBoth;
    logic reloadOne;
    logic reloadThree;
    logic [7:0] data;
  } load_cmd_t;

endpackage

// ### hw/quad_reload_timer.sv
// Purpose: prescaler plus four 8-bit auto-reload down counters
// Assumes: all inputs synchronous to clk_sys except the two timer io pins
// Notes:   index 0..3 stands for timers one..four
//
// Functional notes
// - prescaler divides clock; ratio bit2, run bit3
// - prescaler stopped resets divider, output held low
// - four 8-bit counters; combined load writes both
// - timer one reload-only write spares the count
// - timer three reload-only write spares the count
// - timer one trigger-select waits for start pin zero
// - timer three trigger-select waits for start pin one
// - loaded value n gives underflow every n+1
// - underflow at zero sets flag, reloads, continues
// - timer two source bits 1:0, run bit3
// - timer three source bits 1:0, run bit3
// - timer four source bits 1:0, run bit3
// - flags testable by skip or raise interrupt
// - flag clears on interrupt taken or skip
// - pin control bits 0 and 2 pick functions
// - pin zero outputs t1 half or t1&t2
// - pin one outputs t3 half or t3&t4
// - external source counts rising pin edges
// - timer three codes: t2 underflow, prescaler only
// - timer four codes: t3 underflow, prescaler, pin
module quad_reload_timer #(
  parameter int PreDivSlow = quad_timer_pkg::PRE_DIV_SLOW,
  parameter int PreDivFast = quad_timer_pkg::PRE_DIV_FAST
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // cpu side control and commands
  input wire quad_timer_pkg::timer_ctrl_t ctrl,
  input wire quad_timer_pkg::load_cmd_t cmd,
  input wire logic [3:0] irqEnable,
  input wire logic [3:0] irqTaken,
  input wire logic [3:0] skipExec,
  output logic [3:0][7:0] count,
  output logic [3:0] flag,
  output logic [3:0] irqReq,
  output logic [3:0] skipHit,
  // start trigger pins
  input wire logic startTrigPinZero,
  input wire logic startTrigPinOne,
  // timer io pins
  input wire logic [1:0] ioPinIn,
  output logic [1:0] ioPinOut,
  output logic [1:0] ioPinOe_n,
  output logic prescalerOut
);

  if (PreDivSlow < 1 || PreDivSlow > 256 || PreDivFast < 1 ||
      PreDivFast > 256) begin : g_bad_div
    $error("prescaler ratios must lie in 1..256");
  end

  // ------------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------------
  logic [7:0] preCnt_q;
  logic [7:0] preCnt_d;
  wire preRun = ctrl.oneCtrl[quad_timer_pkg::PRE_RUN];
  wire [7:0] preLast = ctrl.oneCtrl[quad_timer_pkg::PRE_RATIO] ?
    8'(PreDivSlow - 1) : 8'(PreDivFast - 1);
  wire prePulse = preRun && (preCnt_q == preLast);
  assign prescalerOut = prePulse;
  // a stopped divider parks at zero, so each start gives a full period
  // before the first pulse; a ratio change while running alters one, and wraps the 8-bit divider if it is already past the new last count

  always_comb begin
    if (!preRun) begin
      preCnt_d = 8'h00;
    end else if (prePulse) begin
      preCnt_d = 8'h00;
    end else begin
      preCnt_d = preCnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preCnt_q <= 8'h00;
    end else begin
      preCnt_q <= preCnt_d;
    end
  end

  // ------------------------------------------------------------------
  // pin input synchronisers and edge detect
  // ------------------------------------------------------------------
  logic [1:0] pinMeta_q;
  logic [1:0] pinSync_q;
  logic [1:0] pinPrev_q;
  logic [1:0] trigPrev_q;
  logic [1:0] trigLatch_q;
  logic [1:0] trigLatch_d;
  // only the second and third stages are examined; the first may be metastable
  wire [1:0] pinRise = pinSync_q & ~pinPrev_q;
  // a pin level held for less than a clock may be lost
  wire [1:0] trigIn = {startTrigPinOne, startTrigPinZero};
  wire [1:0] trigRise = trigIn & ~trigPrev_q;
  wire [1:0] trigSel = {ctrl.threeCtrl[quad_timer_pkg::THREE_TRIG_SEL],
                        ctrl.oneCtrl[quad_timer_pkg::ONE_TRIG_SEL]};

  // latch stays set until the select bit drops; edge polarity is fixed
  assign trigLatch_d = trigSel & (trigLatch_q | trigRise);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pinMeta_q <= 2'h0;
      pinSync_q <= 2'h0;
      pinPrev_q <= 2'h0;
      trigPrev_q <= 2'h0;
      trigLatch_q <= 2'h0;
    end else begin
      pinMeta_q <= ioPinIn;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
      trigPrev_q <= trigIn;
      trigLatch_q <= trigLatch_d;
    end
  end

  // ------------------------------------------------------------------
  // run gating and count source selection
  // ------------------------------------------------------------------
  logic [3:0] run;
  logic [3:0] srcPulse;
  logic [3:0] underflow;
  logic [3:0][7:0] reload_q;
  wire [1:0] srcTwo = ctrl.twoCtrl[quad_timer_pkg::SRC_HI:0];
  wire [1:0] srcThree = ctrl.threeCtrl[quad_timer_pkg::SRC_HI:0];
  wire [1:0] srcFour = ctrl.fourCtrl[quad_timer_pkg::SRC_HI:0];

  assign run[0] = ctrl.oneCtrl[quad_timer_pkg::ONE_RUN] &&
    (!trigSel[0] || trigLatch_q[0]);
  assign run[1] = ctrl.twoCtrl[quad_timer_pkg::TMR_RUN];
  assign run[2] = ctrl.threeCtrl[quad_timer_pkg::TMR_RUN] &&
    (!trigSel[1] || trigLatch_q[1]);
  assign run[3] = ctrl.fourCtrl[quad_timer_pkg::TMR_RUN];

  // timer one always counts the prescaler output
  assign srcPulse[0] = prePulse;
  // code 11 of timer two has no source inside this block
  assign srcPulse[1] =
    (srcTwo == quad_timer_pkg::SRC_CASCADE) ? underflow[0] :
    (srcTwo == quad_timer_pkg::SRC_PRESCALE) ? prePulse :
    (srcTwo == quad_timer_pkg::SRC_PIN) ? pinRise[0] : 1'b0;
  assign srcPulse[2] =
    (srcThree == quad_timer_pkg::SRC_CASCADE) ? underflow[1] :
    (srcThree == quad_timer_pkg::SRC_PRESCALE) ? prePulse : 1'b0;
  assign srcPulse[3] =
    (srcFour == quad_timer_pkg::SRC_CASCADE) ? underflow[2] :
    (srcFour == quad_timer_pkg::SRC_PRESCALE) ? prePulse :
    (srcFour == quad_timer_pkg::SRC_PIN) ? pinRise[1] : 1'b0;

  // ------------------------------------------------------------------
  // counters, reloads, flags, toggles
  // ------------------------------------------------------------------
  logic [3:0] toggle_q;
  logic [3:0] clearReq;
  wire [3:0] reloadOnly = {1'b0, cmd.reloadThree, 1'b0, cmd.reloadOne};
  // only timers one and three have a reload-only write path

  for (genvar i = 0; i < 4; i++) begin : g_tmr
    logic [7:0] cnt_d;
    logic [7:0] rel_d;
    assign underflow[i] = run[i] && srcPulse[i] &&
      (count[i] == 8'h00);
    assign rel_d = (cmd.loadBoth[i] || reloadOnly[i]) ?
      cmd.data : reload_q[i];
    assign cnt_d = cmd.loadBoth[i] ? cmd.data :
      underflow[i] ? reload_q[i] :
      (run[i] && srcPulse[i]) ? count[i] - 8'h01 : count[i];
    // a set in the same cycle as a clear keeps the flag
    assign clearReq[i] = irqTaken[i] || (skipExec[i] && flag[i]);

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        count[i] <= quad_timer_pkg::CNT_RESET;
        reload_q[i] <= quad_timer_pkg::CNT_RESET;
        flag[i] <= 1'b0;
        toggle_q[i] <= 1'b0;
      end else begin
        count[i] <= cnt_d;
        reload_q[i] <= rel_d;
        flag[i] <= underflow[i] || (flag[i] && !clearReq[i]);
        toggle_q[i] <= toggle_q[i] ^ underflow[i];
      end
    end
  end

  assign irqReq = flag & irqEnable;
  assign skipHit = flag;

  // ------------------------------------------------------------------
  // timer io pin outputs
  // ------------------------------------------------------------------
  // toggles survive a stop, so a paused timer keeps its pin level
  wire pinZeroAnd = ctrl.pinCtrl[quad_timer_pkg::PIN0_AND];
  wire pinOneAnd = ctrl.pinCtrl[quad_timer_pkg::PIN1_AND];
  assign ioPinOut[0] = toggle_q[0] &
    (pinZeroAnd ? toggle_q[1] : 1'b1);
  assign ioPinOut[1] = toggle_q[2] &
    (pinOneAnd ? toggle_q[3] : 1'b1);
  assign ioPinOe_n[0] = !ctrl.pinCtrl[quad_timer_pkg::PIN0_FUNC];
  assign ioPinOe_n[1] = !ctrl.pinCtrl[quad_timer_pkg::PIN1_FUNC];

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  localparam int FastLast = PreDivFast - 1;

  chk_flag_set: assert property (
    underflow[2] |=> flag[2]) else $error("flag not set on underflow");
  chk_reload_take: assert property (
    underflow[0] && !cmd.loadBoth[0] |=> count[0] == $past(reload_q[0]))
    else $error("reload value not taken at underflow");
  chk_load_both: assert property (
    cmd.loadBoth[3] |=> count[3] == $past(cmd.data) &&
    reload_q[3] == $past(cmd.data)) else $error("combined load failed");
  chk_reload_one: assert property (
    cmd.reloadOne && !cmd.loadBoth[0] && !underflow[0] |=>
    reload_q[0] == $past(cmd.data) &&
    count[0] == $past(count[0]) - ($past(run[0] && srcPulse[0]) ?
    8'h01 : 8'h00))
    else $error("reload-only write touched timer one count");
  chk_reload_three: assert property (
    cmd.reloadThree && !cmd.loadBoth[2] && !underflow[2] |=>
    reload_q[2] == $past(cmd.data) &&
    count[2] == $past(count[2]) - ($past(run[2] && srcPulse[2]) ?
    8'h01 : 8'h00)) else $error("reload-only write on timer three wrong");
  chk_pre_stop: assert property (
    !preRun |-> !prescalerOut ##1 preCnt_q == 8'h00)
    else $error("prescaler not held while stopped");
  chk_pre_period: assert property (
    prePulse && preRun && ctrl.oneCtrl[quad_timer_pkg::PRE_RATIO] &&
    $stable(ctrl.oneCtrl) ##1 preRun [*3] |-> !prePulse)
    else $error("prescaler pulse too early");
  chk_trig_gate: assert property (
    trigSel[0] && !trigLatch_q[0] && !cmd.loadBoth[0] |->
    !run[0] ##1 count[0] == $past(count[0]))
    else $error("timer one ran before trigger");
  chk_pin_count: assert property (
    run[3] && srcFour == quad_timer_pkg::SRC_PIN && pinRise[1] &&
    !cmd.loadBoth[3] && count[3] != 8'h00 |=>
    count[3] == $past(count[3]) - 8'h01)
    else $error("timer four missed pin edge");
  chk_toggle_flip: assert property (
    underflow[1] |=> toggle_q[1] != $past(toggle_q[1]))
    else $error("divide-by-two output did not toggle");
  chk_stop_hold: assert property (
    !run[1] && !cmd.loadBoth[1] |=> $stable(count[1]))
    else $error("stopped timer two moved");
  chk_flag_clear: assert property (
    flag[0] && skipExec[0] && !underflow[0] |=> !flag[0])
    else $error("skip did not clear flag");

  // ------------------------------------------------------------------
  // start, cascade and pin checks
  // ------------------------------------------------------------------
  // the divider starts from zero, so the first pulse needs a full period
  chk_pre_first: assert property (
    $rose(preRun) && !ctrl.oneCtrl[quad_timer_pkg::PRE_RATIO] |->
    ##FastLast (prePulse || !preRun))
    else $error("first prescaler pulse misplaced");
  chk_trig_latch: assert property (
    trigSel[1] && startTrigPinOne && !$past(startTrigPinOne) |=>
    trigLatch_q[1]) else $error("start trigger one not latched");
  chk_cascade_three: assert property (
    run[2] && srcThree == quad_timer_pkg::SRC_CASCADE && underflow[1] &&
    !cmd.loadBoth[2] && count[2] != 8'h00 |=>
    count[2] == $past(count[2]) - 8'h01)
    else $error("timer three missed timer two underflow");
  chk_three_idle: assert property (
    srcThree[quad_timer_pkg::SRC_HI] && !cmd.loadBoth[2] |=>
    $stable(count[2])) else $error("timer three counted on a bad code");
  chk_four_idle: assert property (
    (&srcFour) && !cmd.loadBoth[3] |=> $stable(count[3]))
    else $error("timer four counted on a bad code");
  // the edge shows two clocks after the pin is first seen high
  chk_pin_sync: assert property (
    $rose(ioPinIn[0]) |-> ##2 pinRise[0])
    else $error("pin edge not seen after two clocks");
  chk_pin_and: assert property (
    ioPinOut[0] |-> toggle_q[0] && (toggle_q[1] || !pinZeroAnd))
    else $error("pin zero output not the selected half rate");
  chk_pin_drive: assert property (
    ctrl.pinCtrl[quad_timer_pkg::PIN1_FUNC] |-> !ioPinOe_n[1])
    else $error("pin one not driven when selected");

  // ------------------------------------------------------------------
  // flag checks
  // ------------------------------------------------------------------
  // a clear in the same cycle as an underflow must lose
  chk_flag_wins: assert property (
    underflow[0] |=> flag[0]) else $error("underflow lost to a clear");
  chk_irq_clear: assert property (
    irqTaken[1] && !underflow[1] |=> !flag[1])
    else $error("taken interrupt did not clear flag");
  chk_flag_keep: assert property (
    flag[3] && !irqTaken[3] && !skipExec[3] |=> flag[3])
    else $error("flag dropped without a clear");

  cov_underflow: cover property (underflow[0] ##1 flag[0]);
  cov_cascade: cover property (underflow[0] && underflow[1]);
  cov_trig_start: cover property (trigSel[1] && trigRise[1] ##1 run[2]);
  cov_pin_and: cover property (pinZeroAnd && ioPinOut[0]);
  cov_pin_count: cover property (
    run[3] && srcFour == quad_timer_pkg::SRC_PIN && pinRise[1]);

endmodule

// ### verif/pin_partner.sv
// Purpose: far side of the two timer io pins and the start triggers
// Assumes: every change is launched just after a rising clock edge
// Notes:   an io pin is driven here only while the block has released it
module pin_partner (
  // clock
  input wire logic clk_sys,
  // block side of the io pins
  input wire logic [1:0] ioPinOut,
  input wire logic [1:0] ioPinOe_n,
  // resolved pin levels and start triggers
  output logic [1:0] ioPinIn,
  output logic [1:0] trig
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] drv = 2'h0;
  initial trig = 2'h0;
  // the block owns the wire whenever it drives, so it may count itself
  assign ioPinIn = (ioPinOut & ~ioPinOe_n) | (drv & ioPinOe_n);
  // gap sets how slowly the source toggles, n is the rising edge count
  task automatic edges(input int p, input int n, input int gap);
    repeat (2 * n) begin
      repeat (gap) @(posedge clk_sys);
      drv[p] <= ~drv[p];
    end
  endtask
  task automatic fire(input int i);
    @(posedge clk_sys);
    trig[i] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    trig[i] <= 1'b0;
  endtask
endmodule

// ### verif/tb_top.sv
// Purpose: cycle model of the quad timer compared with the block each cycle
// Assumes: short prescaler ratios so that many underflows fit in the run
// Notes:   timer two code 00 counts timer one underflows, as decoded
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Slow = 6;
  localparam int Fast = 3;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  quad_timer_pkg::timer_ctrl_t ctrl = '0;
  quad_timer_pkg::load_cmd_t cmd = '0;
  logic [3:0] irqEnable = 4'h0, irqTaken = 4'h0, skipExec = 4'h0;
  logic [3:0][7:0] count;
  logic [3:0] flag, irqReq, skipHit;
  logic [1:0] trig, pinIn, pinOut, pinOe_n;
  logic preOut, mPre;
  int failures = 0, n_compared = 0, cycles = 0, div = 0;
  int mCnt[4], mRel[4];
  logic [3:0] mFlag, mTog;
  logic [1:0] latch, tPrev;
  logic [1:0][2:0] sy;

  quad_reload_timer #(.PreDivSlow(Slow), .PreDivFast(Fast)) dut (
    .clk_sys(clk_sys), .rst(rst), .ctrl(ctrl), .cmd(cmd),
    .irqEnable(irqEnable), .irqTaken(irqTaken), .skipExec(skipExec),
    .count(count), .flag(flag), .irqReq(irqReq), .skipHit(skipHit),
    .startTrigPinZero(trig[0]), .startTrigPinOne(trig[1]),
    .ioPinIn(pinIn), .ioPinOut(pinOut), .ioPinOe_n(pinOe_n),
    .prescalerOut(preOut));
  pin_partner pp (.clk_sys(clk_sys), .ioPinOut(pinOut),
    .ioPinOe_n(pinOe_n), .ioPinIn(pinIn), .trig(trig));

  initial begin
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  assign mPre = ctrl.oneCtrl[3] && div == (ctrl.oneCtrl[2] ? Slow : Fast) - 1;

  function automatic logic pick(logic [1:0] c, logic up, logic pin);
    return c == 2'h0 ? up : c == 2'h1 ? mPre : c == 2'h2 ? pin : 1'b0;
  endfunction

  always @(posedge clk_sys or posedge rst) begin : model
    logic [3:0] u, r, pv;
    logic [3:0][1:0] src;
    logic pk;
    if (rst) begin
      mCnt = '{default: 0};
      mRel = '{default: 0};
      div = 0;
      {mFlag, mTog, latch, tPrev, sy} = '0;
    end else begin
      src = {ctrl.fourCtrl[1:0], ctrl.threeCtrl[1:0], ctrl.twoCtrl[1:0], 2'h1};
      pv = {sy[1][1] & ~sy[1][2], 1'b0, sy[0][1] & ~sy[0][2], 1'b0};
      r[0] = ctrl.oneCtrl[1] & (~ctrl.oneCtrl[0] | latch[0]);
      r[1] = ctrl.twoCtrl[3];
      r[2] = ctrl.threeCtrl[3] & (~ctrl.threeCtrl[2] | latch[1]);
      r[3] = ctrl.fourCtrl[3];
      for (int t = 0; t < 4; t++) begin
        pk = r[t] & pick(src[t], t > 0 ? u[t-1] : 1'b0, pv[t]);
        u[t] = pk & (mCnt[t] == 0);
        if (cmd.loadBoth[t]) mCnt[t] = cmd.data;
        else if (u[t]) mCnt[t] = mRel[t];
        else if (pk) mCnt[t] = mCnt[t] - 1;
        if (cmd.loadBoth[t] | (t == 0 & cmd.reloadOne)
            | (t == 2 & cmd.reloadThree)) mRel[t] = cmd.data;
        mFlag[t] = u[t] | (mFlag[t] & ~irqTaken[t] & ~skipExec[t]);
        mTog[t] = mTog[t] ^ u[t];
      end
      div = mPre || !ctrl.oneCtrl[3] ? 0 : div + 1;
      latch[0] = ctrl.oneCtrl[0] & (latch[0] | (trig[0] & ~tPrev[0]));
      latch[1] = ctrl.threeCtrl[2] & (latch[1] | (trig[1] & ~tPrev[1]));
      tPrev = trig;
      sy = {sy[1][1:0], pinIn[1], sy[0][1:0], pinIn[0]};
    end
  end

  task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  always @(negedge clk_sys) begin
    if (!rst) begin
      for (int t = 0; t < 4; t++) check("count", count[t], 8'(mCnt[t]));
      check("flags", {flag, skipHit}, {mFlag, mFlag});
      check("irqReq", {4'h0, irqReq}, {4'h0, mFlag & irqEnable});
      check("pins", {3'h0, preOut, pinOe_n, pinOut}, {3'h0, mPre,
        ~ctrl.pinCtrl[2], ~ctrl.pinCtrl[0],
        mTog[2] & (mTog[3] | ~ctrl.pinCtrl[3]),
        mTog[0] & (mTog[1] | ~ctrl.pinCtrl[1])});
    end
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  task automatic load(input int t, input bit relOnly, input logic [7:0] d);
    @(posedge clk_sys);
    cmd.data <= d;
    if (relOnly && t == 0) cmd.reloadOne <= 1'b1;
    else if (relOnly) cmd.reloadThree <= 1'b1;
    else cmd.loadBoth[t] <= 1'b1;
    @(posedge clk_sys);
    cmd <= '0;
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h51042deb));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    irqEnable <= 4'($urandom);
    for (int r = 0; r < 2; r++) begin
      load(0, 1'b0, 8'h00);
      for (int t = 1; t < 4; t++) load(t, 1'b0, 8'($urandom_range(1, 6)));
      ctrl.oneCtrl <= {1'b1, r[0], 2'h2};
      repeat (40) @(posedge clk_sys);
      load(0, 1'b1, 8'($urandom_range(2, 4)));
      repeat (40) @(posedge clk_sys);
      ctrl.oneCtrl[3] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    $display("test prescaler and timer one done");
    for (int c = 0; c < 4; c++) begin
      ctrl.twoCtrl[3] <= 1'b0;
      ctrl.threeCtrl[3] <= 1'b0;
      ctrl.fourCtrl[3] <= 1'b0;
      @(posedge clk_sys);
      ctrl.pinCtrl <= 4'($urandom) & (c[0] ? 4'hf : 4'ha);
      ctrl.twoCtrl <= {2'h2, 2'(c)};
      ctrl.threeCtrl <= {2'h2, 2'(c)};
      ctrl.fourCtrl <= {2'h2, 2'(c)};
      ctrl.oneCtrl <= 4'ha;
      load(1, 1'b0, 8'($urandom_range(0, 1)));
      fork
        pp.edges(0, 8, 3);
        pp.edges(1, 8, 2);
        load(2, 1'b1, 8'($urandom_range(0, 3)));
      join
    end
    $display("test sources and pins done");
    ctrl <= '0;
    @(posedge clk_sys);
    ctrl.oneCtrl <= 4'h3;
    ctrl.threeCtrl <= 4'hd;
    @(posedge clk_sys);
    ctrl.oneCtrl[3] <= 1'b1;
    repeat (20) @(posedge clk_sys);
    ctrl.oneCtrl[3] <= 1'b0;
    pp.fire(0);
    pp.fire(1);
    ctrl.oneCtrl[3] <= 1'b1;
    repeat (30) @(posedge clk_sys);
    $display("test start triggers done");
    ctrl <= '0;
    @(posedge clk_sys);
    skipExec <= 4'h5;
    irqTaken <= 4'h2;
    @(posedge clk_sys);
    skipExec <= 4'hf;
    irqTaken <= 4'h0;
    @(posedge clk_sys);
    skipExec <= 4'h0;
    repeat (2) @(posedge clk_sys);
    $display("test flag clearing done");
    end_sim();
  end
endmodule
